// File: pkg/rsp_pkg.sv
// Shared constants and state types for the reset sequencer and serial programming link.
package rsp_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned POR_DELAY_CYC = 1_000_000;
  localparam int unsigned PWRUP_WAIT_MS = 20;
  localparam int unsigned PWRUP_WAIT_CYC = PWRUP_WAIT_MS * CYC_PER_MS;
  localparam int unsigned WRITE_WAIT_MS = 4;
  localparam int unsigned WRITE_WAIT_CYC = WRITE_WAIT_MS * CYC_PER_MS;
  localparam int unsigned SCK_LOW_MIN_CYC = 4;
  localparam int unsigned SCK_HIGH_MIN_CYC = 16;
  // Half period leaves room for the two-stage sampler on the far side.
  localparam logic [19:0] SCK_HALF_CYC = 20'h00014;
  localparam logic [19:0] RST_PULSE_CYC = 20'h00014;
  localparam logic [1:0] IO_READY_CYC = 2'h2;
  localparam int unsigned FLASH_WORDS = 1024;
  localparam int unsigned EE_BYTES = 128;
  localparam int unsigned IO_BYTES = 64;
  localparam logic [4:0] LAST_BIT = 5'h1f;
  localparam logic [4:0] ADDR_DONE_BIT = 5'h17;
  localparam logic [9:0] VEC_RESET = 10'h000;
  localparam logic [9:0] VEC_TRANSMISSION_COMPLETE_IRQ = 10'h002;
  localparam logic [9:0] VEC_TXEMPTY = 10'h004;
  localparam logic [15:0] RELATIVE_JUMP_INSTR_MASK = 16'hf000;
  localparam logic [15:0] RELATIVE_JUMP_INSTR_CODE = 16'hc000;
  localparam logic [15:0] JMP_MASK = 16'hfe0e;
  localparam logic [15:0] JMP_CODE = 16'h940c;
  localparam logic [1:0] LOCK_RESET = 2'h3;
  localparam logic [4:0] SYNC_IDLE = 5'h04;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] IO_INIT = 8'h00;
  localparam logic [7:0] CMD_PREFIX = 8'hac;
  localparam logic [7:0] CMD_ENABLE_B2 = 8'h53;
  localparam logic [2:0] CMD_ERASE_B2 = 3'h4;
  localparam logic [2:0] CMD_LOCK_B2 = 3'h7;
  localparam logic [7:0] CMD_H_MASK = 8'hf7;
  localparam logic [7:0] CMD_RD_FLASH = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h40;
  localparam logic [7:0] CMD_RD_EE = 8'ha0;
  localparam logic [7:0] CMD_WR_EE = 8'hc0;
  localparam logic [7:0] CMD_RD_IO = 8'hb0;
  localparam logic [7:0] CMD_WR_IO = 8'hd0;
  localparam logic [31:0] ENABLE_FRAME = {CMD_PREFIX, CMD_ENABLE_B2, 16'h0000};

  typedef enum logic [2:0] {
    RSP_ST_POR = 3'b000,
    RSP_ST_CHECK = 3'b001,
    RSP_ST_RUN = 3'b010,
    RSP_ST_NOPROG = 3'b011,
    RSP_ST_EXT = 3'b100,
    RSP_ST_BROWN = 3'b101,
    RSP_ST_BUTTON = 3'b110
  } rsp_dev_st_t;

  typedef enum logic [2:0] {
    RSP_PG_PWRUP = 3'b000,
    RSP_PG_SEND = 3'b001,
    RSP_PG_IDLE = 3'b010,
    RSP_PG_WAIT = 3'b011,
    RSP_PG_PULSE = 3'b100,
    RSP_PG_OFF = 3'b101
  } rsp_prg_st_t;
endpackage

// File: pkg/rsp_link_if.sv
// Serial programming link between the programmer and the device.
interface rsp_link_if;
  logic external_reset_pin_n;
  logic sck;
  logic sdi;
  logic sdo;
  modport dev (input external_reset_pin_n, input sck, input sdi, output sdo);
  modport prg (output external_reset_pin_n, output sck, output sdi, input sdo);
endinterface

// File: design/rsp_device.sv
// Device end: reset sequencing, vectors, lock bits and serial programming of the memories.
// What this block does
// - Power-on waits a million cycles before running.
// - External reset clears I/O, enters programming mode.
// - Watchdog reset restarts at once, no delay.
// - Brown-out holds the device in reset.
// - Button reset exits on button press only.
// - Power-on or watchdog: I/O initialised, fetch zero.
// - No jump at zero means no-program state.
// - Vectors: reset zero, done two, empty four.
// - Interrupts need the global enable bit.
// - Lock bits: none, no writes, no verify.
// - Only chip erase and I_RESET_N clear the lock bits.
// - Programming only while reset pin held low.
// - Flash and EEPROM writes are self-timed and erase the location.
// - Chip erase sets every flash and EEPROM location to ones.
// - Serial clock low four, high sixteen cycles.
// - Programmer powers up with reset, clock low.
// - Programmer waits 20 ms then sends enable.
// - After erase wait, pulse reset, re-enable.
// - One byte per write, 4 ms apart.
// - Read command returns location on serial out.
// - Programmer releases reset to end the session.
// - Enable command is AC 53 plus two bytes.
module rsp_device #(
  parameter int unsigned POR_CYC = rsp_pkg::POR_DELAY_CYC,
  parameter int unsigned WRITE_CYC = rsp_pkg::WRITE_WAIT_CYC
) (
  // Clock and power-on reset
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // Programming link
  rsp_link_if.dev link,
  // Reset sources
  input wire logic I_WDT_RESET,
  input wire logic I_BROWNOUT,
  input wire logic I_BUTTON_RST_REQ,
  input wire logic I_BUTTON_PRESS,
  // Interrupt requests
  input wire logic I_GIE,
  input wire logic I_TRANSMISSION_COMPLETE_IRQ,
  input wire logic I_TX_EMPTY_IRQ,
  // Core status
  output logic [9:0] O_PC,
  output logic [15:0] O_INSTR,
  output logic O_RUNNING,
  output logic O_NO_PROGRAM,
  output logic O_PROG_ENABLED,
  output logic O_PROG_BUSY,
  output logic [1:0] O_LOCK_BITS
);
  import rsp_pkg::*;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic sck_q;
    logic [4:0] bitcnt;
    logic [31:0] sh;
    logic [7:0] osh;
    logic sdo;
    logic prog_en;
    logic [1:0] io_cnt;
    logic [19:0] busy;
    logic [1:0] lock;
    rsp_dev_st_t st;
    logic [19:0] dly;
    logic [9:0] pc;
    logic [15:0] instr;
    logic run_o;
    logic noprog_o;
    logic busy_o;
  } rsp_dev_t;

  // Samplers start at the idle pin levels, so a released reset pin cannot skip the power-on delay.
  localparam rsp_dev_t DEV_INIT = '{st: RSP_ST_POR, lock: LOCK_RESET, s1: SYNC_IDLE, s2: SYNC_IDLE, default: '0};

  logic [7:0] flash_lo [FLASH_WORDS];
  logic [7:0] flash_hi [FLASH_WORDS];
  logic [7:0] ee [EE_BYTES];
  logic [7:0] io [IO_BYTES];

  rsp_dev_t r;
  rsp_dev_t n;
  logic [31:0] fr;
  logic rst_low;
  logic rise;
  logic fall;
  logic io_ready;
  logic fl_we_lo;
  logic fl_we_hi;
  logic ee_we;
  logic io_we;
  logic erase;
  logic io_clr;
  logic [9:0] waddr;
  logic [7:0] wdata;

  function automatic logic is_jump(input logic [15:0] w);
    is_jump = ((w & RELATIVE_JUMP_INSTR_MASK) == RELATIVE_JUMP_INSTR_CODE) || ((w & JMP_MASK) == JMP_CODE);
  endfunction

  always_comb
  begin
    n = r;
    fl_we_lo = 1'b0;
    fl_we_hi = 1'b0;
    ee_we = 1'b0;
    io_we = 1'b0;
    erase = 1'b0;
    io_clr = 1'b0;
    // Only the second sampler stage feeds logic; the pins are asynchronous here.
    n.s1 = {I_BUTTON_PRESS, I_BROWNOUT, link.external_reset_pin_n, link.sck, link.sdi};
    n.s2 = r.s1;
    n.sck_q = r.s2[1];
    rst_low = ~r.s2[2];
    rise = r.s2[1] & ~r.sck_q;
    fall = ~r.s2[1] & r.sck_q;
    io_ready = r.io_cnt == IO_READY_CYC;
    fr = {r.sh[30:0], r.s2[0]};
    waddr = {fr[17:16], fr[15:8]};
    wdata = fr[7:0];
    if (r.busy != 20'h00000)
    begin
      n.busy = r.busy - 20'h00001;
    end
    if (!rst_low)
    begin
      n.bitcnt = 5'h00;
      n.prog_en = 1'b0;
      n.io_cnt = 2'h0;
      n.osh = 8'h00;
      n.sdo = 1'b0;
    end
    else
    begin
      if (!io_ready)
      begin
        n.io_cnt = r.io_cnt + 2'h1;
      end
      if (fall)
      begin
        n.sdo = r.osh[7];
        n.osh = {r.osh[6:0], 1'b0};
      end
      if (rise)
      begin
        n.sh = fr;
        n.bitcnt = r.bitcnt + 5'h01;
        if (r.bitcnt == ADDR_DONE_BIT && r.prog_en)
        begin
          // Verify reads are blocked only when both lock bits are programmed.
          if ((fr[23:16] & CMD_H_MASK) == CMD_RD_FLASH && r.lock != 2'h0)
          begin
            n.osh = fr[19] ? flash_hi[fr[9:0]] : flash_lo[fr[9:0]];
          end
          else if (fr[23:16] == CMD_RD_EE && r.lock != 2'h0)
          begin
            n.osh = ee[fr[6:0]];
          end
          else if (fr[23:16] == CMD_RD_IO && io_ready)
          begin
            n.osh = io[fr[5:0]];
          end
        end
        if (r.bitcnt == LAST_BIT)
        begin
          if (fr[31:24] == CMD_PREFIX && fr[23:16] == CMD_ENABLE_B2)
          begin
            n.prog_en = 1'b1;
          end
          else if (r.prog_en)
          begin
            if (fr[31:24] == CMD_PREFIX && fr[23:21] == CMD_ERASE_B2)
            begin
              erase = 1'b1;
              n.lock = LOCK_RESET;
              n.busy = 20'(WRITE_CYC);
            end
            else if (fr[31:24] == CMD_PREFIX && fr[23:21] == CMD_LOCK_B2 && r.busy == 20'h00000)
            begin
              n.lock = r.lock & {fr[18], fr[17]};
              n.busy = 20'(WRITE_CYC);
            end
            else if ((fr[31:24] & CMD_H_MASK) == CMD_WR_FLASH && r.lock[0] && r.busy == 20'h00000)
            begin
              fl_we_hi = fr[27];
              fl_we_lo = ~fr[27];
              n.busy = 20'(WRITE_CYC);
            end
            else if (fr[31:24] == CMD_WR_EE && r.lock[0] && r.busy == 20'h00000)
            begin
              ee_we = 1'b1;
              n.busy = 20'(WRITE_CYC);
            end
            else if (fr[31:24] == CMD_WR_IO && io_ready)
            begin
              io_we = 1'b1;
            end
          end
        end
      end
    end
    if (rst_low)
    begin
      n.st = RSP_ST_EXT;
      io_clr = r.st != RSP_ST_EXT;
    end
    else if (r.s2[3])
    begin
      n.st = RSP_ST_BROWN;
    end
    else if (I_WDT_RESET)
    begin
      n.st = RSP_ST_CHECK;
      io_clr = 1'b1;
    end
    else
    begin
      unique case (r.st)
        RSP_ST_POR:
        begin
          io_clr = 1'b1;
          if (r.dly >= 20'(POR_CYC - 1))
          begin
            n.st = RSP_ST_CHECK;
          end
          else
          begin
            n.dly = r.dly + 20'h00001;
          end
        end
        RSP_ST_CHECK:
        begin
          n.pc = VEC_RESET;
          n.st = is_jump({flash_hi[VEC_RESET], flash_lo[VEC_RESET]}) ? RSP_ST_RUN : RSP_ST_NOPROG;
        end
        RSP_ST_RUN:
        begin
          if (I_BUTTON_RST_REQ)
          begin
            n.st = RSP_ST_BUTTON;
          end
          else if (I_GIE && I_TRANSMISSION_COMPLETE_IRQ)
          begin
            n.pc = VEC_TRANSMISSION_COMPLETE_IRQ;
          end
          else if (I_GIE && I_TX_EMPTY_IRQ)
          begin
            n.pc = VEC_TXEMPTY;
          end
          else
          begin
            n.pc = r.pc + 10'h001;
          end
        end
        RSP_ST_NOPROG:
        begin
          n.st = RSP_ST_NOPROG;
        end
        RSP_ST_EXT:
        begin
          n.st = RSP_ST_CHECK;
        end
        RSP_ST_BROWN:
        begin
          // Leaving brown-out takes the full settling delay, as supply was lost.
          n.st = RSP_ST_POR;
          n.dly = 20'h00000;
        end
        RSP_ST_BUTTON:
        begin
          if (r.s2[4])
          begin
            n.st = RSP_ST_CHECK;
          end
        end
        default:
        begin
          n.st = RSP_ST_POR;
        end
      endcase
    end
    n.instr = {flash_hi[r.pc], flash_lo[r.pc]};
    n.run_o = n.st == RSP_ST_RUN;
    n.noprog_o = n.st == RSP_ST_NOPROG;
    n.busy_o = n.busy != 20'h00000;
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      r <= DEV_INIT;
    end
    else
    begin
      r <= n;
    end
  end

  // Arrays stay out of the reset so they model nonvolatile storage.
  always_ff @(posedge I_CLK)
  begin
    if (erase)
    begin
      for (int i = 0; i < FLASH_WORDS; i++)
      begin
        flash_lo[i] <= ERASED_BYTE;
        flash_hi[i] <= ERASED_BYTE;
      end
      for (int i = 0; i < EE_BYTES; i++)
      begin
        ee[i] <= ERASED_BYTE;
      end
    end
    else
    begin
      if (fl_we_lo)
      begin
        flash_lo[waddr] <= wdata;
      end
      if (fl_we_hi)
      begin
        flash_hi[waddr] <= wdata;
      end
      if (ee_we)
      begin
        ee[waddr[6:0]] <= wdata;
      end
    end
    if (io_clr)
    begin
      for (int i = 0; i < IO_BYTES; i++)
      begin
        io[i] <= IO_INIT;
      end
    end
    else if (io_we)
    begin
      io[waddr[5:0]] <= wdata;
    end
  end

  assign link.sdo = r.sdo;
  assign O_PC = r.pc;
  assign O_INSTR = r.instr;
  assign O_RUNNING = r.run_o;
  assign O_NO_PROGRAM = r.noprog_o;
  assign O_PROG_ENABLED = r.prog_en;
  assign O_PROG_BUSY = r.busy_o;
  assign O_LOCK_BITS = r.lock;
endmodule

// File: design/rsp_programmer.sv
// Programmer end: power-up, enable, command framing, timed waits and session release.
module rsp_programmer #(
  parameter int unsigned PWRUP_CYC = rsp_pkg::PWRUP_WAIT_CYC,
  parameter int unsigned WRITE_CYC = rsp_pkg::WRITE_WAIT_CYC
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // Programming link
  rsp_link_if.prg link,
  // Command port
  input wire logic I_SESSION,
  input wire logic I_START,
  input wire logic [31:0] I_CMD,
  output logic O_READY,
  output logic O_DONE,
  output logic [7:0] O_RDATA
);
  import rsp_pkg::*;

  typedef struct packed {
    rsp_prg_st_t st;
    logic [19:0] cnt;
    logic [4:0] bitn;
    logic [31:0] sh;
    logic [7:0] rx;
    logic s1;
    logic s2;
    logic user;
    logic is_erase;
    logic is_write;
    logic rst_o;
    logic sck_o;
    logic sdi_o;
    logic ready_o;
    logic done_o;
    logic [7:0] rdata_o;
  } rsp_prg_t;

  rsp_prg_t r;
  rsp_prg_t n;

  always_comb
  begin
    n = r;
    n.s1 = link.sdo;
    n.s2 = r.s1;
    n.done_o = 1'b0;
    n.cnt = r.cnt + 20'h00001;
    unique case (r.st)
      RSP_PG_PWRUP:
      begin
        n.rst_o = 1'b0;
        n.sck_o = 1'b0;
        if (r.cnt >= 20'(PWRUP_CYC - 1))
        begin
          n.cnt = 20'h00000;
          n.st = RSP_PG_SEND;
          n.sh = ENABLE_FRAME;
          n.sdi_o = ENABLE_FRAME[31];
          n.bitn = 5'h00;
          n.user = 1'b0;
          n.is_erase = 1'b0;
          n.is_write = 1'b0;
        end
      end
      RSP_PG_SEND:
      begin
        if (r.cnt >= SCK_HALF_CYC - 20'h00001)
        begin
          n.cnt = 20'h00000;
          if (!r.sck_o)
          begin
            n.sck_o = 1'b1;
            n.rx = {r.rx[6:0], r.s2};
          end
          else
          begin
            n.sck_o = 1'b0;
            n.sh = {r.sh[30:0], 1'b0};
            n.sdi_o = r.sh[30];
            n.bitn = r.bitn + 5'h01;
            if (r.bitn == LAST_BIT)
            begin
              n.sdi_o = 1'b0;
              n.done_o = r.user;
              n.rdata_o = r.user ? r.rx : r.rdata_o;
              n.st = (r.is_erase || r.is_write) ? RSP_PG_WAIT : RSP_PG_IDLE;
            end
          end
        end
      end
      RSP_PG_WAIT:
      begin
        if (r.cnt >= 20'(WRITE_CYC - 1))
        begin
          n.cnt = 20'h00000;
          n.st = r.is_erase ? RSP_PG_PULSE : RSP_PG_IDLE;
        end
      end
      RSP_PG_PULSE:
      begin
        n.rst_o = 1'b1;
        if (r.cnt >= RST_PULSE_CYC - 20'h00001)
        begin
          n.rst_o = 1'b0;
          n.cnt = 20'h00000;
          n.st = RSP_PG_PWRUP;
        end
      end
      RSP_PG_IDLE:
      begin
        n.cnt = 20'h00000;
        if (!I_SESSION)
        begin
          n.rst_o = 1'b1;
          n.st = RSP_PG_OFF;
        end
        else if (I_START)
        begin
          n.st = RSP_PG_SEND;
          n.sh = I_CMD;
          n.sdi_o = I_CMD[31];
          n.bitn = 5'h00;
          n.user = 1'b1;
          n.is_erase = I_CMD[31:24] == CMD_PREFIX && I_CMD[23:21] == CMD_ERASE_B2;
          n.is_write = (I_CMD[31:24] & CMD_H_MASK) == CMD_WR_FLASH || I_CMD[31:24] == CMD_WR_EE
                       || (I_CMD[31:24] == CMD_PREFIX && I_CMD[23:21] == CMD_LOCK_B2);
        end
      end
      RSP_PG_OFF:
      begin
        n.cnt = 20'h00000;
        n.rst_o = 1'b1;
        if (I_SESSION)
        begin
          // Reentry pays the full settling wait so enable always follows it.
          n.rst_o = 1'b0;
          n.st = RSP_PG_PWRUP;
        end
      end
      default:
      begin
        n.st = RSP_PG_PWRUP;
      end
    endcase
    n.ready_o = n.st == RSP_PG_IDLE;
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign link.external_reset_pin_n = r.rst_o;
  assign link.sck = r.sck_o;
  assign link.sdi = r.sdi_o;
  assign O_READY = r.ready_o;
  assign O_DONE = r.done_o;
  assign O_RDATA = r.rdata_o;
endmodule

// File: tb/rsp_link_checker.sv
// Protocol checker watching the serial programming link between the two ends.
module rsp_link_checker #(
  parameter int unsigned PWRUP_CYC = 100
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // Link wires
  input wire logic external_reset_pin_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  logic [7:0] hi_cnt_r;
  logic [31:0] up_cnt_r;
  // The high time is counted because it is longer than a repetition may be written.
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      hi_cnt_r <= 8'h00;
      up_cnt_r <= 32'h0;
    end
    else
    begin
      hi_cnt_r <= sck ? ((hi_cnt_r == 8'hff) ? hi_cnt_r : hi_cnt_r + 8'h01) : 8'h00;
      up_cnt_r <= (up_cnt_r < PWRUP_CYC) ? up_cnt_r + 32'h1 : up_cnt_r;
    end
  end
  property p_sck_low;
    $fell(sck) |-> (!sck) [*4];
  endproperty
  a_sck_low: assert property (p_sck_low) else $error("serial clock low phase too short");
  property p_sck_high;
    $fell(sck) |-> hi_cnt_r >= 8'h10;
  endproperty
  a_sck_high: assert property (p_sck_high) else $error("serial clock high phase too short");
  property p_sck_rst;
    $rose(sck) |-> (sck && !external_reset_pin_n) [*8];
  endproperty
  a_sck_rst: assert property (p_sck_rst) else $error("serial clock active outside reset");
  property p_sck_quiet;
    external_reset_pin_n |-> !sck;
  endproperty
  a_sck_quiet: assert property (p_sck_quiet) else $error("serial clock moves while released");
  property p_sdi_stable;
    sck && $past(sck) |-> $stable(sdi);
  endproperty
  a_sdi_stable: assert property (p_sdi_stable) else $error("serial input moved while clock high");
  property p_sdo_change;
    $changed(sdo) |-> !sck;
  endproperty
  a_sdo_change: assert property (p_sdo_change) else $error("serial output moved while clock high");
  property p_rst_pulse;
    $rose(external_reset_pin_n) |-> external_reset_pin_n [*8];
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");
  property p_pwrup;
    (up_cnt_r + 32'h2 < PWRUP_CYC) |-> (!sck && !external_reset_pin_n);
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("link active during power-up wait");
  c_pulse: cover property ($rose(external_reset_pin_n));
  c_frame: cover property ($fell(sck));
  c_read: cover property ($changed(sdo));
endmodule

// File: tb/reset_and_serial_programming_tb.sv
// Self-checking bench: programmer and device joined by the link, with a byte-level memory model.
module reset_and_serial_programming_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rsp_pkg::*;
  logic I_CLK = 1'b0, I_RESET_N = 1'b0, I_WDT_RESET = 1'b0, I_BROWNOUT = 1'b0;
  logic I_BUTTON_RST_REQ = 1'b0, I_BUTTON_PRESS = 1'b0, I_GIE = 1'b0;
  logic I_TRANSMISSION_COMPLETE_IRQ = 1'b0, I_TX_EMPTY_IRQ = 1'b0;
  logic I_SESSION = 1'b1, I_START = 1'b0;
  logic [31:0] I_CMD = 32'h0;
  logic [9:0] O_PC;
  logic [15:0] O_INSTR;
  logic [1:0] O_LOCK_BITS;
  logic [7:0] O_RDATA;
  logic O_RUNNING, O_NO_PROGRAM, O_PROG_ENABLED, O_PROG_BUSY, O_READY, O_DONE;
  logic [7:0] mem [int];
  logic [1:0] lk = 2'b11;
  int n_errors = 0;
  int compares = 0;
  rsp_link_if rsp_link_if_inst ();
  rsp_device #(.POR_CYC(50), .WRITE_CYC(200)) rsp_device_inst (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
    .link(rsp_link_if_inst.dev), .I_WDT_RESET(I_WDT_RESET), .I_BROWNOUT(I_BROWNOUT),
    .I_BUTTON_RST_REQ(I_BUTTON_RST_REQ), .I_BUTTON_PRESS(I_BUTTON_PRESS), .I_GIE(I_GIE),
    .I_TRANSMISSION_COMPLETE_IRQ(I_TRANSMISSION_COMPLETE_IRQ), .I_TX_EMPTY_IRQ(I_TX_EMPTY_IRQ),
    .O_PC(O_PC), .O_INSTR(O_INSTR), .O_RUNNING(O_RUNNING), .O_NO_PROGRAM(O_NO_PROGRAM),
    .O_PROG_ENABLED(O_PROG_ENABLED), .O_PROG_BUSY(O_PROG_BUSY), .O_LOCK_BITS(O_LOCK_BITS));
  rsp_programmer #(.PWRUP_CYC(100), .WRITE_CYC(300)) rsp_programmer_inst (.I_CLK(I_CLK),
    .I_RESET_N(I_RESET_N), .link(rsp_link_if_inst.prg), .I_SESSION(I_SESSION), .I_START(I_START),
    .I_CMD(I_CMD), .O_READY(O_READY), .O_DONE(O_DONE), .O_RDATA(O_RDATA));
  rsp_link_checker #(.PWRUP_CYC(100)) rsp_link_checker_inst (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
    .external_reset_pin_n(rsp_link_if_inst.external_reset_pin_n), .sck(rsp_link_if_inst.sck),
    .sdi(rsp_link_if_inst.sdi), .sdo(rsp_link_if_inst.sdo));
  always #50 I_CLK = ~I_CLK;
  task automatic complete_run();
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Spaces: 0 flash byte {word,H}, 1 eeprom, 2 I/O, 3 chip erase, 4 lock write with d[1:0].
  task automatic acc(input int sp, input int a, input logic [7:0] d, input bit rd);
    logic [31:0] c;
    logic [7:0] e;
    int k;
    case (sp)
      0: c = {(rd ? CMD_RD_FLASH : CMD_WR_FLASH) | {4'h0, a[0], 3'h0}, 6'h00, a[10:1], d};
      1: c = {rd ? CMD_RD_EE : CMD_WR_EE, 9'h000, a[6:0], d};
      2: c = {rd ? CMD_RD_IO : CMD_WR_IO, 10'h000, a[5:0], d};
      3: c = {CMD_PREFIX, 8'h80, 16'h0000};
      default: c = {CMD_PREFIX, 5'h1c, d[1:0], 1'b0, 16'h0000};
    endcase
    e = (sp == 2) ? 8'h00 : ERASED_BYTE;
    if (mem.exists(sp * 4096 + a))
      e = mem[sp * 4096 + a];
    if (sp < 2 && lk == 2'b00)
      e = 8'h00;
    k = 0;
    while (O_READY !== 1'b1 && k < 20000)
    begin
      @(negedge I_CLK);
      k++;
    end
    @(posedge I_CLK);
    I_START <= 1'b1;
    I_CMD <= c;
    @(posedge I_CLK);
    I_START <= 1'b0;
    k = 0;
    while (O_DONE !== 1'b1 && k < 20000)
    begin
      @(negedge I_CLK);
      k++;
    end
    check("done", {31'h0, O_DONE}, 32'h1);
    if (rd)
      check("rdata", {24'h0, O_RDATA}, {24'h0, e});
    check("busy", {31'h0, O_PROG_BUSY}, {31'h0, sp > 2 || (!rd && sp < 2 && lk[0])});
    check("enabled", {31'h0, O_PROG_ENABLED}, 32'h1);
    if (!rd && (sp == 2 || (sp < 2 && lk[0])))
      mem[sp * 4096 + a] = d;
    if (sp == 3)
      mem.delete();
    lk = (sp == 3) ? 2'b11 : (sp == 4) ? (lk & d[1:0]) : lk;
    check("lock", {30'h0, O_LOCK_BITS}, {30'h0, lk});
  endtask
  task automatic wait_run(input logic v, input int n);
    int k;
    k = 0;
    @(negedge I_CLK);
    while (O_RUNNING !== v && k < n)
    begin
      @(negedge I_CLK);
      k++;
    end
    check("running", {31'h0, O_RUNNING}, {31'h0, v});
  endtask
  task automatic drive_pulse(input int which);
    @(posedge I_CLK);
    I_WDT_RESET <= (which == 0);
    I_BUTTON_RST_REQ <= (which == 1);
    @(posedge I_CLK);
    I_WDT_RESET <= 1'b0;
    I_BUTTON_RST_REQ <= 1'b0;
  endtask
  initial
  begin
    #9_000_000;
    n_errors++;
    complete_run();
  end
  initial
  begin
    int sp;
    int a;
    logic [7:0] d;
    int k;
    void'($urandom(42747));
    repeat (16) @(posedge I_CLK);
    I_RESET_N <= 1'b1;
    acc(3, 0, 8'h00, 1'b0);
    acc(0, 1, 8'h00, 1'b1);
    // A second write over each location proves the built-in erase before writing.
    repeat (6)
    begin
      sp = $urandom_range(2);
      a = (sp == 0) ? $urandom_range(2047, 2) : $urandom_range((sp == 1) ? 127 : 63);
      d = 8'($urandom);
      acc(sp, a, d, 1'b0);
      acc(sp, a, ~d, 1'b0);
      acc(sp, a, 8'h00, 1'b1);
    end
    acc(4, 0, 8'h02, 1'b0);
    acc(1, 5, 8'h5a, 1'b0);
    acc(1, 5, 8'h00, 1'b1);
    acc(4, 0, 8'h00, 1'b0);
    acc(1, 5, 8'h00, 1'b1);
    acc(4, 0, 8'h03, 1'b0);
    acc(3, 0, 8'h00, 1'b0);
    // The erased array holds no jump at zero, so the reset pulse lands in the no-program state.
    k = 0;
    while (O_NO_PROGRAM !== 1'b1 && k < 1000)
    begin
      @(negedge I_CLK);
      k++;
    end
    check("noprog", {31'h0, O_NO_PROGRAM}, 32'h1);
    acc(1, 5, 8'h00, 1'b1);
    acc(0, 0, 8'h00, 1'b0);
    acc(0, 1, 8'hc0, 1'b0);
    acc(0, 1, 8'h00, 1'b1);
    @(posedge I_CLK);
    I_SESSION <= 1'b0;
    wait_run(1'b1, 200);
    check("noprog", {31'h0, O_NO_PROGRAM}, 32'h0);
    check("pc", {22'h0, O_PC}, {22'h0, VEC_RESET});
    @(negedge I_CLK);
    check("instr", {16'h0, O_INSTR}, 32'h0000c000);
    @(posedge I_CLK);
    I_GIE <= 1'b1;
    I_TRANSMISSION_COMPLETE_IRQ <= 1'b1;
    I_TX_EMPTY_IRQ <= 1'b1;
    repeat (4) @(negedge I_CLK);
    check("pc", {22'h0, O_PC}, {22'h0, VEC_TRANSMISSION_COMPLETE_IRQ});
    @(posedge I_CLK);
    I_TRANSMISSION_COMPLETE_IRQ <= 1'b0;
    repeat (4) @(negedge I_CLK);
    check("pc", {22'h0, O_PC}, {22'h0, VEC_TXEMPTY});
    @(posedge I_CLK);
    I_GIE <= 1'b0;
    repeat (8) @(negedge I_CLK);
    check("masked", {22'h0, O_PC}, {22'h0, VEC_TXEMPTY + 10'h007});
    @(posedge I_CLK);
    I_TX_EMPTY_IRQ <= 1'b0;
    drive_pulse(0);
    wait_run(1'b0, 5);
    wait_run(1'b1, 10);
    check("pc", {22'h0, O_PC}, {22'h0, VEC_RESET});
    @(posedge I_CLK);
    I_BROWNOUT <= 1'b1;
    wait_run(1'b0, 10);
    @(posedge I_CLK);
    I_BROWNOUT <= 1'b0;
    repeat (20) @(negedge I_CLK);
    check("por", {31'h0, O_RUNNING}, 32'h0);
    wait_run(1'b1, 100);
    drive_pulse(1);
    wait_run(1'b0, 10);
    repeat (20) @(negedge I_CLK);
    check("button", {31'h0, O_RUNNING}, 32'h0);
    @(posedge I_CLK);
    I_BUTTON_PRESS <= 1'b1;
    wait_run(1'b1, 20);
    @(posedge I_CLK);
    I_BUTTON_PRESS <= 1'b0;
    complete_run();
  end
endmodule
